// file: rtl/core_clock_config.sv
// Core clock ratio decode, bypass and off modes, cache clock control over AXI4-Lite
`timescale 1ns/1ps
module core_clock_config (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [4:0] ratio_sel_i,
	input wire logic bypass_bus_qualifier_i,
	output logic [5:0] core_mult_half_o,
	output logic [6:0] vco_mult_half_o,
	output logic [1:0] mode_o,
	output logic core_clk_en_o,
	output logic bus_tick_o,
	output logic cache_clk_o,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	clk_cfg_pkg::clk_mode_t mode_r;
	clk_cfg_pkg::clk_mode_t mode_nxt;
	logic [5:0] mult_nxt;
	logic [4:0] ratio_r;
	logic [clk_cfg_pkg::RATIO_COUNT-1:0] match;
	logic [3:0] div_code_r;
	logic aw_held_r;
	logic w_held_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] status_word;

	cache_div_if div_link ();

	genvar g;
	generate
		for (g = 0; g < clk_cfg_pkg::RATIO_COUNT; g++) begin : g_match
			assign match[g] = (ratio_sel_i == clk_cfg_pkg::RATIO_CODE[g]);
		end
	endgenerate

	// ratio select chooses mode and multiplier
	always_comb begin
		mult_nxt = clk_cfg_pkg::HALF_NONE;
		for (int i = 0; i < clk_cfg_pkg::RATIO_COUNT; i++) begin
			if (match[i]) begin
				mult_nxt = clk_cfg_pkg::RATIO_HALF[i];
			end
		end
		if (ratio_sel_i == clk_cfg_pkg::CODE_BYPASS) begin
			mode_nxt = clk_cfg_pkg::MODE_BYPASS;
			mult_nxt = clk_cfg_pkg::HALF_BYPASS;
		end else if (|match) begin
			mode_nxt = clk_cfg_pkg::MODE_PLL;
		end else begin
			mode_nxt = clk_cfg_pkg::MODE_OFF;
		end
	end

	// Straps sampled every cycle; board keeps them still, so no filter
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ratio_r <= 5'h00;
			mode_r <= clk_cfg_pkg::MODE_OFF;
			core_mult_half_o <= clk_cfg_pkg::HALF_NONE;
		end else begin
			ratio_r <= ratio_sel_i;
			mode_r <= mode_nxt;
			core_mult_half_o <= mult_nxt;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || mode_nxt != clk_cfg_pkg::MODE_PLL) begin
			vco_mult_half_o <= 7'h00;
		end else begin
			vco_mult_half_o <= {mult_nxt, 1'b0};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			core_clk_en_o <= 1'b0;
		end else begin
			core_clk_en_o <= (mode_nxt != clk_cfg_pkg::MODE_OFF);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bus_tick_o <= 1'b0;
		end else begin
			case (mode_nxt)
				clk_cfg_pkg::MODE_PLL: begin
					bus_tick_o <= 1'b1;
				end
				clk_cfg_pkg::MODE_BYPASS: begin
					bus_tick_o <= bypass_bus_qualifier_i;
				end
				default: begin
					bus_tick_o <= 1'b0;
				end
			endcase
		end
	end

	assign mode_o = mode_r;

	assign div_link.run = core_clk_en_o;
	assign div_link.div_code = div_code_r;
	assign cache_clk_o = div_link.cache_clk;

	cache_clock_divider u_cache_div (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.dv(div_link.div)
	);

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			aw_held_r <= 1'b0;
			awaddr_r <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (aw_held_r && w_held_r) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			w_held_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (aw_held_r && w_held_r) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			div_code_r <= clk_cfg_pkg::DIV_CODE_RESET;
		end else if (aw_held_r && w_held_r && wstrb_r[0]
			&& awaddr_r[3:2] == clk_cfg_pkg::ADDR_CACHE_CTRL[3:2]) begin
			div_code_r <= wdata_r[clk_cfg_pkg::CTRL_DIV_LSB +: 4];
		end
	end

	// Status is read only, so a write there answers with an error
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= clk_cfg_pkg::RESP_OKAY;
		end else if (aw_held_r && w_held_r) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_r[3:2] == clk_cfg_pkg::ADDR_CACHE_CTRL[3:2])
				? clk_cfg_pkg::RESP_OKAY : clk_cfg_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[clk_cfg_pkg::STAT_RATIO_LSB +: 5] = ratio_r;
		status_word[clk_cfg_pkg::STAT_CORE_LSB +: 6] = core_mult_half_o;
		status_word[clk_cfg_pkg::STAT_VCO_LSB +: 7] = vco_mult_half_o;
		status_word[clk_cfg_pkg::STAT_MODE_LSB +: 2] = mode_r;
	end

	// AXI4-Lite read, one outstanding
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= clk_cfg_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr[3:2])
				clk_cfg_pkg::ADDR_CACHE_CTRL[3:2]: begin
					s_axi_rdata <= {28'h000_0000, div_code_r};
					s_axi_rresp <= clk_cfg_pkg::RESP_OKAY;
				end
				clk_cfg_pkg::ADDR_STATUS[3:2]: begin
					s_axi_rdata <= status_word;
					s_axi_rresp <= clk_cfg_pkg::RESP_OKAY;
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= clk_cfg_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	sequence bypass_held_s;
		ratio_sel_i == clk_cfg_pkg::CODE_BYPASS ##1 ratio_sel_i == clk_cfg_pkg::CODE_BYPASS;
	endsequence

	sequence bypass_state_s;
		mode_o == clk_cfg_pkg::MODE_BYPASS && core_clk_en_o && vco_mult_half_o == 7'h00;
	endsequence

	ratio_nine_a: assert property (ratio_sel_i == clk_cfg_pkg::CODE_9P5 |=> core_mult_half_o == clk_cfg_pkg::HALF_9P5
		&& mode_o == clk_cfg_pkg::MODE_PLL)
		else $error("code 01110 did not give 9.5x");
	ratio_top_a: assert property (ratio_sel_i == clk_cfg_pkg::CODE_28 |=> core_mult_half_o == clk_cfg_pkg::HALF_28)
		else $error("code 11101 did not give 28x");
	vco_double_a: assert property (mode_o == clk_cfg_pkg::MODE_PLL |-> vco_mult_half_o == {core_mult_half_o, 1'b0})
		else $error("oscillator not twice core");
	bypass_core_a: assert property (bypass_held_s |=> bypass_state_s and ##0 core_mult_half_o == clk_cfg_pkg::HALF_BYPASS)
		else $error("bypass code did not clock core from reference");
	bypass_bus_a: assert property (ratio_sel_i == clk_cfg_pkg::CODE_BYPASS |=> bus_tick_o == $past(bypass_bus_qualifier_i))
		else $error("bypass bus not paced by qualifier");
	off_stops_a: assert property (ratio_sel_i == clk_cfg_pkg::CODE_OFF |=> !core_clk_en_o && !bus_tick_o
		##1 !cache_clk_o)
		else $error("off code left clocks running");
	reserved_off_a: assert property (!(|match) && ratio_sel_i != clk_cfg_pkg::CODE_BYPASS
		|=> mode_o == clk_cfg_pkg::MODE_OFF && core_mult_half_o == clk_cfg_pkg::HALF_NONE)
		else $error("reserved code not treated as off");
	mode_mult_a: assert property ((mode_o == clk_cfg_pkg::MODE_PLL) == (vco_mult_half_o != 7'h00))
		else $error("mode and oscillator disagree");
	div_write_a: assert property (aw_held_r && w_held_r && wstrb_r[0] && awaddr_r == clk_cfg_pkg::ADDR_CACHE_CTRL
		|=> div_code_r == $past(wdata_r[3:0]) && s_axi_bvalid)
		else $error("divisor write not applied");
endmodule : core_clock_config

// file: rtl/clk_cfg_pkg.sv
// Constants, types and ratio table for the core and cache clock configuration block
// Function
// - Decode five-bit ratio select into multiplier
// - Oscillator runs at twice core in PLL mode, held at zero in bypass and off
// - Code 00110 bypasses multiplier, reference clocks core
// - Bypass: bus half rate, core full rate
// - Code 11110 stops all internal clocking
// - Cache SRAM clock divided from core
// - Thirteen cache divisors, two to eight
// - Ratio select sets core and oscillator
package clk_cfg_pkg;
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_PLL = 2'b01,
		MODE_BYPASS = 2'b10
	} clk_mode_t;

	// Ratio table, multipliers held in half units
	localparam int RATIO_COUNT = 30;
	localparam logic [4:0] RATIO_CODE [RATIO_COUNT] = '{
		5'h08, 5'h10, 5'h14, 5'h16, 5'h12, 5'h1A, 5'h0A, 5'h04, 5'h02, 5'h18,
		5'h0C, 5'h0F, 5'h0E, 5'h15, 5'h11, 5'h13, 5'h00, 5'h17, 5'h1F, 5'h0B,
		5'h1C, 5'h19, 5'h03, 5'h1B, 5'h01, 5'h05, 5'h07, 5'h09, 5'h0D, 5'h1D};
	localparam logic [5:0] RATIO_HALF [RATIO_COUNT] = '{
		6'h04, 6'h06, 6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10,
		6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A,
		6'h1B, 6'h1C, 6'h1E, 6'h20, 6'h22, 6'h24, 6'h28, 6'h2A, 6'h30, 6'h38};
	localparam logic [4:0] CODE_BYPASS = 5'h06;
	localparam logic [4:0] CODE_OFF = 5'h1E;
	localparam logic [5:0] HALF_BYPASS = 6'h02;
	localparam logic [5:0] HALF_NONE = 6'h00;
	localparam logic [5:0] HALF_9P5 = 6'h13;
	localparam logic [5:0] HALF_28 = 6'h38;
	localparam logic [4:0] CODE_9P5 = 5'h0E;
	localparam logic [4:0] CODE_28 = 5'h1D;

	// Cache divisor: quarter-cycle accumulator, divisor in half units
	localparam logic [3:0] DIV_CODE_MAX = 4'hC;
	localparam logic [4:0] DIV_BASE_HALF = 5'h04;
	localparam logic [4:0] DIV_STEP = 5'h04;
	localparam logic [3:0] DIV_CODE_RESET = 4'h0;

	// Register map
	localparam logic [3:0] ADDR_CACHE_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int CTRL_DIV_LSB = 0;
	localparam int STAT_RATIO_LSB = 0;
	localparam int STAT_CORE_LSB = 5;
	localparam int STAT_VCO_LSB = 11;
	localparam int STAT_MODE_LSB = 18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : clk_cfg_pkg

// file: rtl/cache_div_if.sv
// Link between the configuration core and the cache clock divider
`timescale 1ns/1ps
interface cache_div_if;
	logic run;
	logic [3:0] div_code;
	logic cache_clk;
	modport ctrl (output run, output div_code, input cache_clk);
	modport div (input run, input div_code, output cache_clk);
endinterface : cache_div_if

// file: rtl/cache_clock_divider.sv
// Fractional cache SRAM clock divider running on core ticks
`timescale 1ns/1ps
module cache_clock_divider (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	cache_div_if.div dv
);
	logic [4:0] acc_r;
	logic [4:0] acc_sum;
	logic [4:0] div_half;
	logic active;

	assign acc_sum = acc_r + clk_cfg_pkg::DIV_STEP;
	assign div_half = clk_cfg_pkg::DIV_BASE_HALF + {1'b0, dv.div_code};
	// Unused field codes park the clock rather than guess a ratio
	assign active = dv.run && (dv.div_code <= clk_cfg_pkg::DIV_CODE_MAX);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || !active) begin
			acc_r <= 5'h00;
			dv.cache_clk <= 1'b0;
		end else if (acc_sum >= div_half) begin
			acc_r <= acc_sum - div_half;
			dv.cache_clk <= ~dv.cache_clk;
		end else begin
			acc_r <= acc_sum;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	div_two_a: assert property ((active && dv.div_code == 4'h0) [*2] |-> dv.cache_clk != $past(dv.cache_clk))
		else $error("divide by two did not toggle every tick");
	div_stop_a: assert property (!active |=> !dv.cache_clk && acc_r == 5'h00)
		else $error("cache clock ran while stopped");
	// Any phase on entry: four ticks at divide by eight give exactly one toggle
	div_eight_a: assert property ((active && dv.div_code == 4'hC) [*4] |=> dv.cache_clk != $past(dv.cache_clk, 4))
		else $error("divide by eight toggle spacing wrong");
endmodule : cache_clock_divider

// file: verif/strap_board_model.sv
// Board model: ratio strap and bypass bus qualifier
`timescale 1ns/1ps
module strap_board_model (
	input wire logic ref_clk_i,
	input wire logic [4:0] code_i,
	output logic [4:0] ratio_sel_o,
	output logic qual_o
);
	initial begin
		ratio_sel_o = clk_cfg_pkg::CODE_OFF;
		qual_o = 1'b0;
	end
	always @(posedge ref_clk_i) begin
		ratio_sel_o <= code_i;
	end
	always @(posedge ref_clk_i) begin
		qual_o <= (ratio_sel_o == clk_cfg_pkg::CODE_BYPASS) ? ~qual_o : 1'b0;
	end
endmodule : strap_board_model

// file: verif/core_and_cache_clock_config_tb.sv
// Self-checking bench for the core and cache clock configuration block
`timescale 1ns/1ps
module core_and_cache_clock_config_tb;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [4:0] code = 5'h1E;
	logic [4:0] ratio_sel;
	logic qual, core_en, bus_tick, cache_clk, awready, wready, bvalid, arready, rvalid;
	logic [5:0] core_mult;
	logic [6:0] vco_mult;
	logic [1:0] mode, bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] wdata = 32'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	int n_fail = 0;
	int num_checks = 0;

	strap_board_model board (.ref_clk_i(ref_clk_i), .code_i(code), .ratio_sel_o(ratio_sel), .qual_o(qual));
	core_clock_config dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ratio_sel_i(ratio_sel),
		.bypass_bus_qualifier_i(qual), .core_mult_half_o(core_mult), .vco_mult_half_o(vco_mult),
		.mode_o(mode), .core_clk_en_o(core_en), .bus_tick_o(bus_tick), .cache_clk_o(cache_clk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1));

	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Ready is decoded from registers only, so its value at the falling edge is what the next rising edge sees
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		bit ta, tw, tb;
		logic [1:0] r;
		int n;
		n = 0;
		tb = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!tb && n < 50) begin
			@(negedge ref_clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge ref_clk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end
		chk({tb, r}, {1'b1, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit ta, tr;
		logic [33:0] v;
		int n;
		n = 0;
		tr = 0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!tr && n < 50) begin
			@(negedge ref_clk_i);
			ta = arvalid && arready;
			tr = rvalid;
			v = {rresp, rdata};
			@(posedge ref_clk_i);
			if (ta) arvalid <= 1'b0;
			n++;
		end
		chk({tr, v}, {1'b1, er, ed});
	endtask : axi_rd

	// Reference decode: table lookup, bypass at 1x, anything else off
	task automatic dec(input logic [4:0] c);
		int h;
		int v;
		logic [1:0] m;
		h = 0;
		m = clk_cfg_pkg::MODE_OFF;
		for (int i = 0; i < clk_cfg_pkg::RATIO_COUNT; i++) begin
			if (clk_cfg_pkg::RATIO_CODE[i] == c) begin
				h = clk_cfg_pkg::RATIO_HALF[i];
				m = clk_cfg_pkg::MODE_PLL;
			end
		end
		if (c == clk_cfg_pkg::CODE_BYPASS) begin
			h = 2;
			m = clk_cfg_pkg::MODE_BYPASS;
		end
		v = (m == clk_cfg_pkg::MODE_PLL) ? 2 * h : 0;
		code <= c;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk({mode, core_mult, vco_mult, core_en}, {m, h[5:0], v[6:0], m != clk_cfg_pkg::MODE_OFF});
		if (m != clk_cfg_pkg::MODE_BYPASS) chk(bus_tick, m == clk_cfg_pkg::MODE_PLL);
		@(posedge ref_clk_i);
		axi_rd(clk_cfg_pkg::ADDR_STATUS, {12'h0, m, v[6:0], h[5:0], c}, clk_cfg_pkg::RESP_OKAY);
	endtask : dec

	// Cycles spanned by four cache clock periods, skipping the first rise
	task automatic gap(output int p);
		int r;
		logic pv;
		p = 0;
		r = 0;
		pv = cache_clk;
		for (int k = 0; k < 200 && r < 6; k++) begin
			@(negedge ref_clk_i);
			if (r >= 2) p++;
			if (cache_clk && !pv) r++;
			if (r == 2 && cache_clk && !pv) p = 0;
			pv = cache_clk;
		end
		if (r < 6) p = -1;
		@(posedge ref_clk_i);
	endtask : gap

	initial begin
		#(40 * 20000);
		n_fail++;
		stop_test;
	end

	initial begin
		int ord[32];
		int j, t, p;
		logic [31:0] d;
		t = $urandom(8);
		foreach (ord[i]) ord[i] = i;
		foreach (ord[i]) begin
			j = $urandom % 32;
			t = ord[i];
			ord[i] = ord[j];
			ord[j] = t;
		end
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		axi_rd(clk_cfg_pkg::ADDR_CACHE_CTRL, 32'h0, clk_cfg_pkg::RESP_OKAY);
		foreach (ord[i]) dec(ord[i][4:0]);
		dec(clk_cfg_pkg::CODE_9P5);
		@(negedge ref_clk_i);
		chk(core_mult, clk_cfg_pkg::HALF_9P5);
		dec(clk_cfg_pkg::CODE_28);
		@(negedge ref_clk_i);
		chk(core_mult, clk_cfg_pkg::HALF_28);
		@(posedge ref_clk_i);
		dec(clk_cfg_pkg::CODE_BYPASS);
		@(negedge ref_clk_i);
		for (int i = 0; i < 8; i++) begin
			t = qual;
			@(negedge ref_clk_i);
			chk(bus_tick, t);
		end
		@(posedge ref_clk_i);
		dec(5'h0E);
		// only listed divisor codes, plus one spare code
		for (int n = 0; n < 14; n++) begin
			d = $urandom;
			d[3:0] = n;
			axi_wr(clk_cfg_pkg::ADDR_CACHE_CTRL, d, 4'hF, clk_cfg_pkg::RESP_OKAY);
			axi_rd(clk_cfg_pkg::ADDR_CACHE_CTRL, n, clk_cfg_pkg::RESP_OKAY);
			gap(p);
			chk(p, (n < 13) ? 8 + 2 * n : -1);
		end
		axi_wr(clk_cfg_pkg::ADDR_CACHE_CTRL, 32'h5, 4'hE, clk_cfg_pkg::RESP_OKAY);
		axi_rd(clk_cfg_pkg::ADDR_CACHE_CTRL, 32'hD, clk_cfg_pkg::RESP_OKAY);
		axi_wr(clk_cfg_pkg::ADDR_STATUS, 32'h1, 4'hF, clk_cfg_pkg::RESP_SLVERR);
		axi_rd(4'h8, 32'h0, clk_cfg_pkg::RESP_SLVERR);
		axi_wr(clk_cfg_pkg::ADDR_CACHE_CTRL, 32'h7, 4'hF, clk_cfg_pkg::RESP_OKAY);
		dec(clk_cfg_pkg::CODE_OFF);
		gap(p);
		chk(p, -1);
		dec(5'h0E);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk({mode, core_mult, vco_mult, core_en, bus_tick, cache_clk}, 0);
		@(posedge ref_clk_i);
		axi_rd(clk_cfg_pkg::ADDR_CACHE_CTRL, 32'h0, clk_cfg_pkg::RESP_OKAY);
		stop_test;
	end
endmodule : core_and_cache_clock_config_tb
